// *** design/cvc_defs.svh ***
// Functional notes
// - linear mode: line through two points
// - offset mode: input plus constant
// - characteristic holds 2 to 20 points
// - added point goes after selected point
// - delete refused at two points
// - output from enclosing segment slope, offset
// - outside range extrapolate first/last segment
// - import copies template; template stays unchanged
// - filter disabled passes sample unaltered
// - smoothing: x*(1-k) + previous*k
// - zero time constant turns smoothing off
// - peak detector: peaks or valleys mode
// - extreme recognised after reversal by amount
// - new peak replaces held, restarts hold
// - held peak shown until hold expires
// - external source above zero clears peak
// - rounding disabled keeps full precision
// - standard: digit 0-4 down, 5-9 up
// - floor rounding always downward
// - ceil rounding always upward
`ifndef CVC_DEFS_SVH
`define CVC_DEFS_SVH

// values are fixed point, one unit is 0.0001
`define CVC_FRAC_DIGITS 4
`define CVC_ONE 10000
`define CVC_NPT_MAX 20
`define CVC_NPT_MIN 2
`define CVC_Q16_ONE 65536
`define CVC_Q16_SHIFT 16
// nominal sample period the smoothing coefficient assumes
`define CVC_SAMPLE_MS 100
`define CVC_RST_X0 0
`define CVC_RST_Y0 0
`define CVC_RST_X1 10000
`define CVC_RST_Y1 10000
`define CVC_FIFO_DEPTH 16

`endif

// *** design/cvc_pkg.sv ***
package cvc_pkg;
  typedef enum logic [1:0] {
    SCALE_OFF, SCALE_LINEAR, SCALE_OFFSET, SCALE_USER
  } cvc_scale_t;
  typedef enum logic [1:0] {FILT_OFF, FILT_SMOOTH, FILT_PEAK} cvc_filt_t;
  typedef enum logic [1:0] {
    ROUND_OFF, ROUND_STD, ROUND_FLOOR, ROUND_CEIL
  } cvc_round_t;
  typedef enum logic {PEAK_MAX, PEAK_MIN} cvc_peak_t;
  typedef enum logic [2:0] {
    PCMD_WRITE, PCMD_ADD, PCMD_DEL, PCMD_IMPORT, PCMD_EXPORT
  } cvc_pcmd_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SORT, ST_SEG, ST_DIV, ST_FILT, ST_ROUND, ST_PUSH
  } cvc_state_t;
endpackage

// *** design/cvc_fifo.sv ***
`timescale 1ns/1ps
module cvc_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } cvc_fifo_st_t;
  cvc_fifo_st_t s_q, s_d;
  logic full, empty;

  assign empty = (s_q.wr == s_q.rd);
  assign full = (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]) &&
                (s_q.wr[AW] != s_q.rd[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = s_q.mem[s_q.rd[AW-1:0]];

  always_comb begin
    s_d = s_q;
    if (in_valid && !full) begin
      s_d.mem[s_q.wr[AW-1:0]] = in_data;
      s_d.wr = s_q.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      s_d.rd = s_q.rd + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// *** design/cvc_div.sv ***
`timescale 1ns/1ps
module cvc_div #(
  parameter int NW = 64,
  parameter int DW = 32
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic start,
  input wire logic signed [NW-1:0] num,
  input wire logic signed [DW-1:0] den,
  output logic done,
  output logic signed [NW-1:0] quo
);
  localparam int CW = $clog2(NW) + 1;
  typedef struct packed {
    logic busy;
    logic done;
    logic neg;
    logic [CW-1:0] cnt;
    logic [NW-1:0] q;
    logic [DW:0] r;
    logic [DW:0] d;
  } cvc_div_st_t;
  cvc_div_st_t s_q, s_d;
  logic [DW:0] shifted;

  assign done = s_q.done;
  assign quo = s_q.q;

  // restoring division on magnitudes, one quotient bit per cycle;
  // slow but small, and a sample every 0.1 s leaves plenty of time
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    shifted = {s_q.r[DW-1:0], s_q.q[NW-1]};
    if (start && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.neg = num[NW-1] ^ den[DW-1];
      s_d.q = num[NW-1] ? NW'(-num) : num;
      s_d.d = den[DW-1] ? (DW+1)'(-den) : {1'b0, den};
      s_d.r = '0;
      s_d.cnt = CW'(NW);
    end else if (s_q.busy) begin
      s_d.q = {s_q.q[NW-2:0], 1'b0};
      s_d.r = shifted;
      if (shifted >= s_q.d) begin
        s_d.r = shifted - s_q.d;
        s_d.q[0] = 1'b1;
      end
      s_d.cnt = s_q.cnt - 1'b1;
      if (s_q.cnt == CW'(1)) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        if (s_q.neg) begin
          s_d.q = NW'(-s_d.q);
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// *** design/cvc_channel.sv ***
`timescale 1ns/1ps
`include "cvc_defs.svh"
module cvc_channel #(
  parameter int DW = 32,
  parameter int NPT = `CVC_NPT_MAX,
  parameter int FIFO_DEPTH = `CVC_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic signed [DW-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic signed [DW-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  input wire cvc_pkg::cvc_scale_t scale_mode,
  input wire logic signed [DW-1:0] lin_x1,
  input wire logic signed [DW-1:0] lin_y1,
  input wire logic signed [DW-1:0] lin_x2,
  input wire logic signed [DW-1:0] lin_y2,
  input wire logic signed [DW-1:0] offset_val,
  input wire logic pt_cmd_valid,
  input wire cvc_pkg::cvc_pcmd_t pt_cmd,
  input wire logic [4:0] pt_sel,
  input wire logic signed [DW-1:0] pt_x,
  input wire logic signed [DW-1:0] pt_y,
  output logic [4:0] point_count,
  output logic cmd_refused,
  input wire cvc_pkg::cvc_filt_t filter_mode,
  input wire logic [15:0] decay_time,
  input wire logic [15:0] smooth_k,
  input wire cvc_pkg::cvc_peak_t peak_mode,
  input wire logic signed [DW-1:0] peak_amount,
  input wire logic [15:0] hold_samples,
  input wire logic ext_reset_en,
  input wire logic signed [DW-1:0] ext_reset_val,
  input wire cvc_pkg::cvc_round_t round_mode,
  input wire logic [2:0] precision
);
  typedef struct packed {
    cvc_pkg::cvc_state_t state;
    logic [NPT-1:0][DW-1:0] px;
    logic [NPT-1:0][DW-1:0] py;
    logic [NPT-1:0][DW-1:0] tx;
    logic [NPT-1:0][DW-1:0] ty;
    logic [4:0] n;
    logic [4:0] tn;
    logic [4:0] sidx;
    logic swapped;
    logic refused;
    logic [DW-1:0] x;
    logic [DW-1:0] ya;
    logic [DW-1:0] work;
    logic sm_init;
    logic [DW-1:0] sm_y;
    logic [DW-1:0] cand;
    logic [DW-1:0] held;
    logic [15:0] hold_cnt;
    logic pk_init;
  } cvc_chan_st_t;

  cvc_chan_st_t s_q, s_d;
  logic push, fifo_ready, dstart, ddone;
  logic [4:0] seg;
  logic signed [DW-1:0] xa, ya, xb, yb;
  logic signed [63:0] dnum, dquo, mix;
  logic signed [DW-1:0] dden, v, fo;

  // quantum of the selected precision in 0.0001 units
  function automatic logic signed [DW-1:0] quantum(input logic [2:0] p);
    case (p)
      3'd0: quantum = DW'(`CVC_ONE);
      3'd1: quantum = DW'(1000);
      3'd2: quantum = DW'(100);
      3'd3: quantum = DW'(10);
      default: quantum = DW'(1);
    endcase
  endfunction

  function automatic logic signed [DW-1:0] round_val(
    input logic signed [DW-1:0] a,
    input cvc_pkg::cvc_round_t m,
    input logic [2:0] p
  );
    logic signed [DW-1:0] q;
    logic signed [DW-1:0] r;
    logic signed [DW-1:0] dn;
    q = quantum(p);
    r = a % q;
    if (r < 0) begin
      r = r + q;
    end
    dn = a - r;
    case (m)
      cvc_pkg::ROUND_STD: round_val = (r >= (q >>> 1) && q > 1) ?
                                      dn + q : dn;
      cvc_pkg::ROUND_FLOOR: round_val = dn;
      cvc_pkg::ROUND_CEIL: round_val = (r == 0) ? dn : dn + q;
      default: round_val = a;
    endcase
  endfunction

  assign point_count = s_q.n;
  assign cmd_refused = s_q.refused;
  assign in_ready = (s_q.state == cvc_pkg::ST_IDLE) && !pt_cmd_valid;

  // segment whose bounding points enclose the sample; the first and
  // last segments cover everything below and above the point range
  always_comb begin
    seg = 5'(s_q.n - 5'd2);
    for (int i = NPT - 2; i >= 1; i--) begin
      if (5'(i) <= 5'(s_q.n - 5'd2) &&
          $signed(s_q.x) < $signed(s_q.px[i])) begin
        seg = 5'(i - 1);
      end
    end
  end

  always_comb begin
    if (scale_mode == cvc_pkg::SCALE_LINEAR) begin
      xa = lin_x1;
      ya = lin_y1;
      xb = lin_x2;
      yb = lin_y2;
    end else begin
      xa = $signed(s_q.px[seg]);
      ya = $signed(s_q.py[seg]);
      xb = $signed(s_q.px[5'(seg + 5'd1)]);
      yb = $signed(s_q.py[5'(seg + 5'd1)]);
    end
    dnum = 64'($signed(DW'($signed(s_q.x) - xa))) *
           64'($signed(DW'(yb - ya)));
    dden = DW'(xb - xa);
  end

  always_comb begin
    s_d = s_q;
    s_d.refused = 1'b0;
    push = 1'b0;
    dstart = 1'b0;
    v = $signed(s_q.work);
    fo = v;
    mix = '0;
    case (s_q.state)
      cvc_pkg::ST_IDLE: begin
        if (pt_cmd_valid) begin
          s_d.state = cvc_pkg::ST_SORT;
          s_d.sidx = '0;
          s_d.swapped = 1'b0;
          case (pt_cmd)
            cvc_pkg::PCMD_WRITE: begin
              if (pt_sel < s_q.n) begin
                s_d.px[pt_sel] = pt_x;
                s_d.py[pt_sel] = pt_y;
              end else begin
                s_d.refused = 1'b1;
                s_d.state = cvc_pkg::ST_IDLE;
              end
            end
            cvc_pkg::PCMD_ADD: begin
              if (s_q.n < 5'(NPT) && pt_sel < s_q.n) begin
                for (int j = 1; j < NPT; j++) begin
                  if (j > int'(pt_sel) + 1) begin
                    s_d.px[j] = s_q.px[j-1];
                    s_d.py[j] = s_q.py[j-1];
                  end else if (j == int'(pt_sel) + 1) begin
                    s_d.px[j] = pt_x;
                    s_d.py[j] = pt_y;
                  end
                end
                s_d.n = s_q.n + 5'd1;
              end else begin
                s_d.refused = 1'b1;
                s_d.state = cvc_pkg::ST_IDLE;
              end
            end
            cvc_pkg::PCMD_DEL: begin
              if (s_q.n > 5'(`CVC_NPT_MIN) && pt_sel < s_q.n) begin
                for (int j = 0; j < NPT - 1; j++) begin
                  if (j >= int'(pt_sel)) begin
                    s_d.px[j] = s_q.px[j+1];
                    s_d.py[j] = s_q.py[j+1];
                  end
                end
                s_d.n = s_q.n - 5'd1;
              end else begin
                s_d.refused = 1'b1;
                s_d.state = cvc_pkg::ST_IDLE;
              end
            end
            cvc_pkg::PCMD_IMPORT: begin
              // a copy: later edits touch px/py only, never tx/ty
              s_d.px = s_q.tx;
              s_d.py = s_q.ty;
              s_d.n = s_q.tn;
            end
            cvc_pkg::PCMD_EXPORT: begin
              s_d.tx = s_q.px;
              s_d.ty = s_q.py;
              s_d.tn = s_q.n;
              s_d.state = cvc_pkg::ST_IDLE;
            end
            default: begin
              s_d.refused = 1'b1;
              s_d.state = cvc_pkg::ST_IDLE;
            end
          endcase
        end else if (in_valid) begin
          s_d.x = in_data;
          s_d.state = cvc_pkg::ST_SEG;
        end
      end
      cvc_pkg::ST_SORT: begin
        // one bubble step per cycle; repeats passes until clean
        if ($signed(s_q.px[s_q.sidx]) >
            $signed(s_q.px[5'(s_q.sidx + 5'd1)])) begin
          s_d.px[s_q.sidx] = s_q.px[5'(s_q.sidx + 5'd1)];
          s_d.py[s_q.sidx] = s_q.py[5'(s_q.sidx + 5'd1)];
          s_d.px[5'(s_q.sidx + 5'd1)] = s_q.px[s_q.sidx];
          s_d.py[5'(s_q.sidx + 5'd1)] = s_q.py[s_q.sidx];
          s_d.swapped = 1'b1;
        end
        if (5'(s_q.sidx + 5'd2) >= s_q.n) begin
          s_d.sidx = '0;
          s_d.swapped = 1'b0;
          if (!s_d.swapped && !s_q.swapped &&
              $signed(s_q.px[s_q.sidx]) <=
              $signed(s_q.px[5'(s_q.sidx + 5'd1)])) begin
            s_d.state = cvc_pkg::ST_IDLE;
          end
        end else begin
          s_d.sidx = s_q.sidx + 5'd1;
        end
      end
      cvc_pkg::ST_SEG: begin
        s_d.state = cvc_pkg::ST_FILT;
        case (scale_mode)
          cvc_pkg::SCALE_OFFSET:
            s_d.work = DW'($signed(s_q.x) + offset_val);
          cvc_pkg::SCALE_LINEAR, cvc_pkg::SCALE_USER: begin
            // coincident inputs would divide by zero; output the first point's y (ya)
            if (dden == 0) begin
              s_d.work = ya;
            end else begin
              s_d.ya = ya;
              dstart = 1'b1;
              s_d.state = cvc_pkg::ST_DIV;
            end
          end
          default: s_d.work = s_q.x;
        endcase
      end
      cvc_pkg::ST_DIV: begin
        if (ddone) begin
          s_d.work = DW'($signed(s_q.ya) + $signed(DW'(dquo)));
          s_d.state = cvc_pkg::ST_FILT;
        end
      end
      cvc_pkg::ST_FILT: begin
        case (filter_mode)
          cvc_pkg::FILT_SMOOTH: begin
            if (decay_time == '0 || !s_q.sm_init) begin
              s_d.sm_y = v;
              s_d.sm_init = (decay_time != '0);
            end else begin
              mix = 64'(v) * 64'($signed({1'b0, 17'(`CVC_Q16_ONE) -
                                          17'(smooth_k)})) +
                    64'($signed(s_q.sm_y)) *
                    64'($signed({1'b0, smooth_k}));
              fo = DW'(mix >>> `CVC_Q16_SHIFT);
              s_d.sm_y = fo;
            end
          end
          cvc_pkg::FILT_PEAK: begin
            if (s_q.hold_cnt != '0) begin
              s_d.hold_cnt = s_q.hold_cnt - 16'd1;
            end
            // first sample seeds the tracker; a cleared zero is no extreme
            if (!s_q.pk_init || (ext_reset_en && ext_reset_val > 0)) begin
              s_d.hold_cnt = '0;
              s_d.cand = v;
              s_d.pk_init = 1'b1;
            end else if (peak_mode == cvc_pkg::PEAK_MAX) begin
              if (v > $signed(s_q.cand)) begin
                s_d.cand = v;
              end else if ($signed(s_q.cand) - v >= peak_amount) begin
                s_d.held = s_q.cand;
                s_d.hold_cnt = hold_samples;
                s_d.cand = v;
              end
            end else begin
              if (v < $signed(s_q.cand)) begin
                s_d.cand = v;
              end else if (v - $signed(s_q.cand) >= peak_amount) begin
                s_d.held = s_q.cand;
                s_d.hold_cnt = hold_samples;
                s_d.cand = v;
              end
            end
            fo = (s_d.hold_cnt != '0) ? $signed(s_d.held) : v;
          end
          default: fo = v;
        endcase
        s_d.work = fo;
        s_d.state = cvc_pkg::ST_ROUND;
      end
      cvc_pkg::ST_ROUND: begin
        s_d.work = round_val(v, round_mode, precision);
        s_d.state = cvc_pkg::ST_PUSH;
      end
      cvc_pkg::ST_PUSH: begin
        // a full output buffer stalls here and so holds off new input
        push = 1'b1;
        if (fifo_ready) begin
          s_d.state = cvc_pkg::ST_IDLE;
        end
      end
      default: s_d.state = cvc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.state <= cvc_pkg::ST_IDLE;
      s_q.n <= 5'(`CVC_NPT_MIN);
      s_q.tn <= 5'(`CVC_NPT_MIN);
      s_q.px[0] <= DW'(`CVC_RST_X0);
      s_q.py[0] <= DW'(`CVC_RST_Y0);
      s_q.px[1] <= DW'(`CVC_RST_X1);
      s_q.py[1] <= DW'(`CVC_RST_Y1);
      s_q.tx[0] <= DW'(`CVC_RST_X0);
      s_q.ty[0] <= DW'(`CVC_RST_Y0);
      s_q.tx[1] <= DW'(`CVC_RST_X1);
      s_q.ty[1] <= DW'(`CVC_RST_Y1);
    end else begin
      s_q <= s_d;
    end
  end

  cvc_div #(.NW(64), .DW(DW)) u_div (
    .ref_clk(ref_clk),
    .srst(srst),
    .start(dstart),
    .num(dnum),
    .den(dden),
    .done(ddone),
    .quo(dquo)
  );

  cvc_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_data(s_q.work),
    .in_valid(push),
    .in_ready(fifo_ready),
    .out_data(out_data),
    .out_valid(out_valid),
    .out_ready(out_ready)
  );
endmodule

// *** test/cvc_channel_properties.sv ***
`timescale 1ns/1ps
module cvc_channel_properties #(
  parameter int DW = 32
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic signed [DW-1:0] in_data,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic signed [DW-1:0] out_data,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire cvc_pkg::cvc_scale_t scale_mode,
  input wire logic signed [DW-1:0] offset_val,
  input wire logic pt_cmd_valid,
  input wire cvc_pkg::cvc_pcmd_t pt_cmd,
  input wire logic [4:0] pt_sel,
  input wire logic [4:0] point_count,
  input wire logic cmd_refused,
  input wire cvc_pkg::cvc_filt_t filter_mode,
  input wire cvc_pkg::cvc_round_t round_mode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // commands count only when the block sat idle the cycle before
  logic idle_q;
  logic take, plain, add_c, del_c;
  always_ff @(posedge ref_clk) begin
    idle_q <= in_ready && !in_valid && !pt_cmd_valid;
  end
  assign take = in_valid && in_ready;
  assign plain = take && !out_valid && filter_mode == cvc_pkg::FILT_OFF
    && round_mode == cvc_pkg::ROUND_OFF;
  assign add_c = pt_cmd_valid && idle_q && pt_cmd == cvc_pkg::PCMD_ADD;
  assign del_c = pt_cmd_valid && idle_q && pt_cmd == cvc_pkg::PCMD_DEL;
  property p_rst_state;
    $fell(srst) |-> point_count == 5'h02 && !out_valid && !cmd_refused;
  endproperty
  a_rst_state: assert property (p_rst_state)
    else $error("state after reset wrong");
  property p_count_range;
    point_count >= 5'h02 && point_count <= 5'h14;
  endproperty
  a_count_range: assert property (p_count_range)
    else $error("point count out of range");
  property p_add_ok;
    add_c && point_count < 5'h14 && pt_sel < point_count |=>
      point_count == $past(point_count) + 5'h01 && !cmd_refused;
  endproperty
  a_add_ok: assert property (p_add_ok)
    else $error("add did not grow count");
  property p_add_full;
    add_c && point_count == 5'h14 |=> cmd_refused && point_count == 5'h14;
  endproperty
  a_add_full: assert property (p_add_full)
    else $error("add at full list not refused");
  property p_del_min;
    del_c && point_count == 5'h02 |=> cmd_refused ##1
      !cmd_refused && point_count == 5'h02;
  endproperty
  a_del_min: assert property (p_del_min)
    else $error("delete at two points not refused");
  property p_del_ok;
    del_c && point_count > 5'h02 && pt_sel < point_count |=>
      point_count == $past(point_count) - 5'h01;
  endproperty
  a_del_ok: assert property (p_del_ok)
    else $error("delete did not shrink count");
  property p_busy;
    take |=> !in_ready [*4];
  endproperty
  a_busy: assert property (p_busy)
    else $error("sample taken while busy");
  property p_offset;
    plain && scale_mode == cvc_pkg::SCALE_OFFSET |-> ##5 out_valid &&
      out_data == $past(in_data, 5) + $past(offset_val, 5);
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset result wrong");
  property p_pass;
    plain && scale_mode == cvc_pkg::SCALE_OFF |-> ##5 out_valid &&
      out_data == $past(in_data, 5);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass-through result wrong");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed while stalled");
  c_pair: cover property (take ##5 out_valid);
  c_refuse: cover property (cmd_refused);
  c_stall: cover property (out_valid && !out_ready [*8]);
endmodule

bind cvc_channel cvc_channel_properties #(.DW(DW)) chk_u (
  .ref_clk(ref_clk), .srst(srst), .in_data(in_data),
  .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
  .out_valid(out_valid), .out_ready(out_ready), .scale_mode(scale_mode),
  .offset_val(offset_val), .pt_cmd_valid(pt_cmd_valid), .pt_cmd(pt_cmd),
  .pt_sel(pt_sel), .point_count(point_count), .cmd_refused(cmd_refused),
  .filter_mode(filter_mode), .round_mode(round_mode)
);

// *** test/cvc_partner.sv ***
`timescale 1ns/1ps
module cvc_partner #(
  parameter int DW = 32
) (
  input wire logic ref_clk,
  input wire logic in_ready,
  output logic signed [DW-1:0] in_data,
  output logic in_valid,
  input wire logic signed [DW-1:0] out_data,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic stall
);
  logic signed [DW-1:0] got[$];
  initial begin
    in_data = '0;
    in_valid = 1'b0;
  end
  assign out_ready = !stall;
  always @(posedge ref_clk) begin
    if (out_valid && out_ready) got.push_back(out_data);
  end
  task automatic send(input logic signed [DW-1:0] v, output bit ok);
    int n;
    ok = 1'b0;
    in_data <= v;
    in_valid <= 1'b1;
    for (n = 0; n < 200 && !ok; n++) begin
      @(posedge ref_clk);
      ok = in_ready;
    end
    // stale data would mask a sink that samples outside the handshake
    in_data <= ~v;
    in_valid <= 1'b0;
  endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  typedef struct {
    logic [1:0] sc;
    logic [1:0] rm;
    logic [2:0] pr;
    logic signed [31:0] x;
    logic signed [31:0] y;
  } cvc_row_t;
  logic ref_clk, in_valid, in_ready, out_valid, out_ready, cmd_refused;
  logic srst = 1'b1, stall = 1'b0, pt_cmd_valid = 1'b0, ext_reset_en = 1'b0;
  logic signed [31:0] in_data, out_data, pt_x = '0, pt_y = '0;
  logic signed [31:0] lin_x1 = -32'sh7a120, lin_y1 = -32'sh8d9a0;
  logic signed [31:0] lin_x2 = 32'shcf850, lin_y2 = 32'sh1c3a90;
  logic signed [31:0] offset_val = 32'sh3e8, peak_amount = 32'sh3e8;
  logic signed [31:0] ext_reset_val = '0;
  logic [15:0] decay_time = 16'h0, smooth_k = 16'h0, hold_samples = 16'h3;
  logic [4:0] pt_sel = 5'h0, point_count, cnt;
  logic [2:0] precision = 3'h0;
  logic rf;
  cvc_pkg::cvc_scale_t scale_mode = cvc_pkg::SCALE_OFF;
  cvc_pkg::cvc_filt_t filter_mode = cvc_pkg::FILT_OFF;
  cvc_pkg::cvc_round_t round_mode = cvc_pkg::ROUND_OFF;
  cvc_pkg::cvc_peak_t peak_mode = cvc_pkg::PEAK_MAX;
  cvc_pkg::cvc_pcmd_t pt_cmd = cvc_pkg::PCMD_WRITE;
  int err_count = 0, n_tests = 0;
  cvc_row_t rows [15] = '{
    '{2'h0, 2'h0, 3'h2, 32'sh8707, 32'sh8707},
    '{2'h2, 2'h0, 3'h0, 32'sh8707, 32'sh8aef},
    '{2'h1, 2'h0, 3'h0, 32'shf4240, 32'sh205940},
    '{2'h0, 2'h1, 3'h0, 32'sh8707, 32'sh7530},
    '{2'h0, 2'h1, 3'h2, 32'sh8707, 32'sh8728},
    '{2'h0, 2'h1, 3'h3, 32'sh8707, 32'sh870a},
    '{2'h0, 2'h1, 3'h4, 32'sh8707, 32'sh8707},
    '{2'h0, 2'h1, 3'h2, 32'sh86f5, 32'sh86c4},
    '{2'h0, 2'h2, 3'h1, 32'sh8707, 32'sh84d0},
    '{2'h0, 2'h2, 3'h3, 32'sh8707, 32'sh8700},
    '{2'h0, 2'h3, 3'h0, 32'sh8707, 32'sh9c40},
    '{2'h0, 2'h3, 3'h2, 32'sh8707, 32'sh8728},
    '{2'h0, 2'h1, 3'h1, -32'sh30d4, -32'sh2ee0},
    '{2'h0, 2'h2, 3'h1, -32'sh30d4, -32'sh32c8},
    '{2'h0, 2'h3, 3'h1, -32'sh30a2, -32'sh2ee0}
  };
  cvc_channel dut_u (
    .ref_clk(ref_clk), .srst(srst), .in_data(in_data),
    .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
    .out_valid(out_valid), .out_ready(out_ready), .scale_mode(scale_mode),
    .lin_x1(lin_x1), .lin_y1(lin_y1), .lin_x2(lin_x2), .lin_y2(lin_y2),
    .offset_val(offset_val), .pt_cmd_valid(pt_cmd_valid), .pt_cmd(pt_cmd),
    .pt_sel(pt_sel), .pt_x(pt_x), .pt_y(pt_y), .point_count(point_count),
    .cmd_refused(cmd_refused), .filter_mode(filter_mode),
    .decay_time(decay_time), .smooth_k(smooth_k), .peak_mode(peak_mode),
    .peak_amount(peak_amount), .hold_samples(hold_samples),
    .ext_reset_en(ext_reset_en), .ext_reset_val(ext_reset_val),
    .round_mode(round_mode), .precision(precision)
  );
  cvc_partner prt_u (
    .ref_clk(ref_clk), .in_ready(in_ready), .in_data(in_data),
    .in_valid(in_valid), .out_data(out_data), .out_valid(out_valid),
    .out_ready(out_ready), .stall(stall)
  );
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    results();
  endtask
  task automatic ck(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rst();
    srst <= 1'b1;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic step(input logic signed [31:0] v, input logic [31:0] e);
    int n;
    bit ok;
    prt_u.send(v, ok);
    for (n = 0; n < 200 && prt_u.got.size() == 0; n++) @(posedge ref_clk);
    if (!ok || prt_u.got.size() == 0) tmo();
    ck("sample out", e, prt_u.got.pop_front());
  endtask
  task automatic cmd(input cvc_pkg::cvc_pcmd_t c, input logic [4:0] s,
      input logic signed [31:0] x, input logic signed [31:0] v);
    int n;
    pt_cmd <= c;
    pt_sel <= s;
    pt_x <= x;
    pt_y <= v;
    pt_cmd_valid <= 1'b1;
    @(posedge ref_clk);
    pt_cmd_valid <= 1'b0;
    @(posedge ref_clk);
    rf = cmd_refused;
    cnt = point_count;
    for (n = 0; n < 100 && !in_ready; n++) @(posedge ref_clk);
    if (!in_ready) tmo();
  endtask
  initial begin
    int i, k;
    bit ok;
    rst();
    ck("count", 32'h2, 32'(point_count));
    ck("out_valid", 32'h0, 32'(out_valid));
    foreach (rows[j]) begin
      scale_mode <= cvc_pkg::cvc_scale_t'(rows[j].sc);
      round_mode <= cvc_pkg::cvc_round_t'(rows[j].rm);
      precision <= rows[j].pr;
      step(rows[j].x, rows[j].y);
    end
    scale_mode <= cvc_pkg::SCALE_USER;
    round_mode <= cvc_pkg::ROUND_OFF;
    // placed after point 0 but larger than point 1, so it must move
    cmd(cvc_pkg::PCMD_ADD, 5'h0, 32'sh4e20, 32'sh9c40);
    ck("count", 32'h3, 32'(cnt));
    cmd(cvc_pkg::PCMD_EXPORT, 5'h0, 32'sh0, 32'sh0);
    cmd(cvc_pkg::PCMD_DEL, 5'h2, 32'sh0, 32'sh0);
    ck("count", 32'h2, 32'(cnt));
    cmd(cvc_pkg::PCMD_IMPORT, 5'h0, 32'sh0, 32'sh0);
    ck("count", 32'h3, 32'(cnt));
    step(32'sh3a98, 32'sh61a8);
    step(32'sh7530, 32'sh11170);
    step(-32'sh2710, -32'sh2710);
    cmd(cvc_pkg::PCMD_DEL, 5'h2, 32'sh0, 32'sh0);
    cmd(cvc_pkg::PCMD_DEL, 5'h0, 32'sh0, 32'sh0);
    ck("refused", 32'h1, 32'(rf));
    cmd(cvc_pkg::PCMD_ADD, 5'h5, 32'sh9c40, 32'sh0);
    ck("refused", 32'h1, 32'(rf));
    cmd(cvc_pkg::PCMD_WRITE, 5'h1, 32'sh2710, 32'sh4e20);
    step(32'sh1388, 32'sh2710);
    for (i = 2; i < 20; i++) begin
      cmd(cvc_pkg::PCMD_ADD, 5'(i - 1), 32'(i * 32'h2710), 32'sh0);
      ck("count", 32'(i + 1), 32'(cnt));
    end
    cmd(cvc_pkg::PCMD_ADD, 5'h13, 32'sh30d40, 32'sh0);
    ck("refused", 32'h1, 32'(rf));
    ck("count", 32'h14, 32'(cnt));
    rst();
    scale_mode <= cvc_pkg::SCALE_OFF;
    filter_mode <= cvc_pkg::FILT_SMOOTH;
    decay_time <= 16'h1;
    smooth_k <= 16'h8000;
    step(32'sh4e20, 32'sh4e20);
    step(32'sh0, 32'sh2710);
    step(32'sh0, 32'sh1388);
    decay_time <= 16'h0;
    step(32'sh7530, 32'sh7530);
    rst();
    filter_mode <= cvc_pkg::FILT_PEAK;
    step(32'sh0, 32'sh0);
    step(32'sh2710, 32'sh2710);
    step(32'sh251c, 32'sh251c);
    step(32'sh1f40, 32'sh2710);
    ext_reset_en <= 1'b1;
    ext_reset_val <= 32'sh1;
    step(32'sh1b58, 32'sh1b58);
    rst();
    ext_reset_en <= 1'b0;
    peak_mode <= cvc_pkg::PEAK_MIN;
    step(32'sh2710, 32'sh2710);
    step(32'sh0, 32'sh0);
    step(32'sh7d0, 32'sh0);
    step(-32'sh1388, 32'sh0);
    step(-32'shbb8, -32'sh1388);
    repeat (2) step(-32'shbb8, -32'sh1388);
    step(-32'shbb8, -32'shbb8);
    rst();
    filter_mode <= cvc_pkg::FILT_OFF;
    stall <= 1'b1;
    // the 17th sample may be parked in the block or refused outright
    for (i = 0; i < 17; i++) begin
      prt_u.send(32'(i), ok);
      // an edge between transfers, so valid is never driven twice at once
      @(posedge ref_clk);
      if (!ok && i < 16) tmo();
    end
    k = ok ? 17 : 16;
    i = 0;
    repeat (30) begin
      @(posedge ref_clk);
      if (in_ready !== 1'b0) i++;
    end
    ck("ready when full", 32'h0, 32'(i));
    stall <= 1'b0;
    for (i = 0; i < 100 && prt_u.got.size() < k; i++) @(posedge ref_clk);
    if (prt_u.got.size() < k) tmo();
    for (i = 0; i < k; i++) ck("fifo order", 32'(i), prt_u.got[i]);
    results();
  end
endmodule
